//--- common/pea_pkg.sv
// shared constants and types of the paged effective address unit
package pea_pkg;
   localparam int          WORD_W       = 12;
   localparam int          PAGE_W       = 5;
   localparam int          OFS_W        = 7;
   localparam int          FIELD_W      = 3;
   localparam int          PAGES        = 32;
   localparam int          PAGE_WORDS   = 128;
   localparam logic [11:0] INT_SAVE_A   = 12'h000;
   localparam logic [11:0] INT_VEC_A    = 12'h001;
   localparam logic [11:0] AUTO_LO_A    = 12'h008;
   localparam logic [11:0] AUTO_HI_A    = 12'h00F;
   localparam logic [11:0] PC_RST       = 12'h000;
   localparam int          IR_IND_BIT   = 8;
   localparam int          IR_PAGE_BIT  = 7;
   localparam logic [2:0]  OP_AND       = 3'h0;
   localparam logic [2:0]  OP_TWOS_ADD  = 3'h1;
   localparam logic [2:0]  OP_INC_SKIP  = 3'h2;
   localparam logic [2:0]  OP_DEP_CLR   = 3'h3;
   localparam logic [2:0]  OP_SUB_CALL  = 3'h4;
   localparam logic [2:0]  OP_JUMP      = 3'h5;
   localparam real         MEM_CYCLE_US = 1.6;
   localparam real         CLK_MHZ      = 10.0;
   localparam int          MEM_CYC_CLKS = int'(MEM_CYCLE_US * CLK_MHZ);

   typedef enum logic [2:0] {
      PEA_IDLE  = 3'b000,
      PEA_IPTR  = 3'b001,
      PEA_WBACK = 3'b011,
      PEA_DONE  = 3'b010,
      PEA_INTR  = 3'b110
   } pea_state_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [11:0] wdata;
      logic        rd;
      logic        wr;
      logic [2:0]  field;
   } pea_mem_req_t;

   typedef struct packed {
      logic [11:0] ea;
      logic [2:0]  opcode;
      logic        valid;
      logic        ind;
   } pea_result_t;
endpackage

//--- verilog/pea_cycle_timer.sv
// memory cycle timer: pulses done after a fixed count of clocks
`timescale 1ns/100ps
module pea_cycle_timer
   import pea_pkg::*;
#(
   parameter int CYCLES = MEM_CYC_CLKS
) (
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   input  wire logic start_i,
   output logic      done_o
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       busy;
      logic       done;
   } pea_tmr_t;

   localparam logic [7:0] LAST = 8'(CYCLES - 1);
   pea_tmr_t s_q, s_d;

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (start_i) begin
         s_d.busy = 1'b1;
         s_d.cnt  = 8'h00;
      end else if (s_q.busy) begin
         if (s_q.cnt == LAST) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign done_o = s_q.done;
endmodule

//--- verilog/pea_unit.sv
// effective address former for paged memory reference instructions
`timescale 1ns/100ps
// What this block does
// - a field is 32 pages of 128 words: top five bits page, low seven word.
// - the instruction pointer counts over all 12 bits across pages.
// - an interrupt stores the pointer at 0000 and continues from 0001.
// - the in-page offset comes from instruction bits 0 to 6.
// - page bit one picks the instruction's page, zero picks page zero.
// - page bit and offset form an 8-bit local address, 000-377 octal.
// - with the indirect bit set the pointer word is the full address.
// - indirect through 10-17 with the page bit zero increments the pointer, writes it, uses it.
// - the field comes from the field selection input, not the address.
// - six memory reference operations, each direct or indirect.
// - indirect adds one memory cycle to fetch the pointer.
module pea_unit
   import pea_pkg::*;
#(
   parameter int CYC_CLKS = MEM_CYC_CLKS
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_n_i,
   input  wire logic         instr_valid_i,
   input  wire logic [11:0]  instr_i,
   input  wire logic         advance_i,
   input  wire logic         skip_i,
   input  wire logic         load_pc_i,
   input  wire logic [11:0]  load_pc_val_i,
   input  wire logic         intr_i,
   input  wire logic [2:0]   data_field_i,
   input  wire logic [11:0]  mem_rdata_i,
   output pea_mem_req_t      mem_req_o,
   output pea_result_t       result_o,
   output logic [7:0]        local_addr_o,
   output logic [11:0]       instruction_pointer_o,
   output logic              busy_o
);
   // one record holds every register of the unit
   typedef struct packed {
      pea_state_t   st;
      logic [11:0]  instruction_pointer;
      logic [11:0]  instr_addr;
      logic [11:0]  ir;
      logic [11:0]  ptr_addr;
      logic [7:0]   local_addr;
      pea_mem_req_t req;
      pea_result_t  res;
      logic         tmr_start;
      logic         busy;
      logic         ptr_sent;
   } pea_state_rec_t;

   pea_state_rec_t s_q, s_d;
   logic           cyc_done;
   logic [11:0]    direct_a;
   logic [4:0]     cur_page;
   logic           is_mref;
   logic           auto_hit;
   logic [2:0]     in_op;
   logic           in_ind;
   logic           in_page;
   logic [6:0]     in_ofs;
   logic           bit_and_op;
   logic           twos_add_op;
   logic           increment_skip_zero_op;
   logic           deposit_clear_op;
   logic           subroutine_call_op;
   logic           jump_op;
   logic           take_intr;
   logic           take_instr;
   logic           take_load;
   logic           take_adv;
   logic [11:0]    auto_next;
   logic [11:0]    step_ip;

   pea_cycle_timer #(
      .CYCLES (CYC_CLKS)
   ) u_timer (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .start_i   (s_q.tmr_start),
      .done_o    (cyc_done)
   );

   // split the incoming word into its fields before anything is taken
   always_comb begin
      in_op   = instr_i[11:9];
      in_ind  = instr_i[IR_IND_BIT];
      in_page = instr_i[IR_PAGE_BIT];
      in_ofs  = instr_i[OFS_W-1:0];
      bit_and_op             = in_op == OP_AND;
      twos_add_op            = in_op == OP_TWOS_ADD;
      increment_skip_zero_op = in_op == OP_INC_SKIP;
      deposit_clear_op       = in_op == OP_DEP_CLR;
      subroutine_call_op     = in_op == OP_SUB_CALL;
      jump_op                = in_op == OP_JUMP;
      // codes 6 and 7 belong to other instruction classes
      is_mref = bit_and_op | twos_add_op | increment_skip_zero_op |
                deposit_clear_op | subroutine_call_op | jump_op;
   end

   // interrupt first, then an instruction, then a jump load, then a step
   always_comb begin
      take_intr  = intr_i;
      take_instr = !intr_i && instr_valid_i && is_mref;
      take_load  = !intr_i && !take_instr && load_pc_i;
      take_adv   = !intr_i && !take_instr && !load_pc_i && advance_i;
      step_ip    = skip_i ? 12'h002 : 12'h001;
      // a pointer at 7777 rolls to 0000 since only 12 bits are kept
      auto_next  = mem_rdata_i + 12'h001;
   end

   always_comb begin
      // page is from the latched instruction address, not the pointer
      cur_page = s_q.instr_addr[11:OFS_W];
      direct_a = {(s_q.ir[IR_PAGE_BIT] ? cur_page : 5'h00),
                  s_q.ir[OFS_W-1:0]};
      // only autoindex when reached through an indirect reference
      auto_hit = s_q.ir[IR_IND_BIT] && !s_q.ir[IR_PAGE_BIT] &&
                 direct_a >= AUTO_LO_A && direct_a <= AUTO_HI_A;
   end

   always_comb begin
      s_d               = s_q;
      s_d.tmr_start     = 1'b0;
      s_d.req.rd        = 1'b0;
      s_d.req.wr        = 1'b0;
      s_d.res.valid     = 1'b0;
      // the instruction address bits never choose the field
      s_d.req.field     = data_field_i;
      unique case (s_q.st)
         PEA_IDLE: begin
            if (take_intr) begin
               s_d.req.addr  = INT_SAVE_A;
               s_d.req.wdata = s_q.instruction_pointer;
               s_d.req.wr    = 1'b1;
               s_d.tmr_start = 1'b1;
               s_d.st        = PEA_INTR;
            end else if (take_instr) begin
               s_d.ir         = instr_i;
               s_d.instr_addr = s_q.instruction_pointer;
               s_d.local_addr = {in_page, in_ofs};
               s_d.instruction_pointer =
                  s_q.instruction_pointer + 12'h001;
               s_d.st = PEA_DONE;
               if (in_ind) begin
                  s_d.st = PEA_IPTR;
               end
            end else if (take_load) begin
               s_d.instruction_pointer = load_pc_val_i;
            end else if (take_adv) begin
               // full-width count, so page ends roll into the next page
               s_d.instruction_pointer =
                  s_q.instruction_pointer + step_ip;
            end
         end
         PEA_IPTR: begin
            // pointer fetch costs one memory cycle of its own
            // a sent flag, not an address compare, so a pointer word at
            // 7777 is still fetched
            if (!s_q.ptr_sent) begin
               s_d.ptr_sent  = 1'b1;
               s_d.req.addr  = direct_a;
               s_d.req.rd    = 1'b1;
               s_d.ptr_addr  = direct_a;
               s_d.tmr_start = 1'b1;
            end else if (cyc_done) begin
               if (auto_hit) begin
                  s_d.req.addr  = s_q.ptr_addr;
                  s_d.req.wdata = auto_next;
                  s_d.req.wr    = 1'b1;
                  s_d.res.ea    = auto_next;
                  s_d.tmr_start = 1'b1;
                  s_d.st        = PEA_WBACK;
               end else begin
                  s_d.res.ea = mem_rdata_i;
                  s_d.st     = PEA_DONE;
               end
            end
         end
         PEA_WBACK: begin
            // the result waits until the bumped pointer is written back
            if (cyc_done) begin
               s_d.st = PEA_DONE;
            end
         end
         PEA_DONE: begin
            if (!s_q.ir[IR_IND_BIT]) begin
               s_d.res.ea = direct_a;
            end
            s_d.res.opcode = s_q.ir[11:9];
            s_d.res.ind    = s_q.ir[IR_IND_BIT];
            s_d.res.valid  = 1'b1;
            s_d.ptr_addr   = '1;
            s_d.ptr_sent   = 1'b0;
            s_d.st         = PEA_IDLE;
         end
         PEA_INTR: begin
            // the vector is loaded only once the save write has finished
            if (cyc_done) begin
               s_d.instruction_pointer = INT_VEC_A;
               s_d.st                  = PEA_IDLE;
            end
         end
         default: begin
            s_d.st = PEA_IDLE;
         end
      endcase
      // busy is registered so the pin comes straight from a flip-flop
      s_d.busy = s_d.st != PEA_IDLE;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q                     <= '0;
         s_q.st                  <= PEA_IDLE;
         s_q.instruction_pointer <= PC_RST;
         s_q.ptr_addr            <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign mem_req_o             = s_q.req;
   assign result_o              = s_q.res;
   assign local_addr_o          = s_q.local_addr;
   assign instruction_pointer_o = s_q.instruction_pointer;
   assign busy_o                = s_q.busy;
endmodule

//--- tb/pea_unit_sva.sv
// assertion checker for the paged effective address unit
`timescale 1ns/100ps
module pea_unit_sva
   import pea_pkg::*;
(
   input wire logic         clk_sys_i,
   input wire logic         rst_n_i,
   input wire logic         instr_valid_i,
   input wire logic [11:0]  instr_i,
   input wire logic         advance_i,
   input wire logic         load_pc_i,
   input wire logic         intr_i,
   input wire logic [2:0]   data_field_i,
   input wire pea_mem_req_t mem_req_o,
   input wire pea_result_t  result_o,
   input wire logic [7:0]   local_addr_o,
   input wire logic [11:0]  instruction_pointer_o,
   input wire logic         busy_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   logic        take;
   logic [11:0] dea;
   assign take = !busy_o && instr_valid_i && instr_i[11:9] <= 3'h5 && !intr_i;
   assign dea = {instr_i[7] ? instruction_pointer_o[11:7] : 5'h00,
                 instr_i[6:0]};
   chk_direct_ea: assert property (
      take && !instr_i[8] |-> ##2 result_o.valid &&
      result_o.ea == $past(dea, 2))
      else $error("direct address wrong");
   chk_local_addr: assert property (
      take |=> local_addr_o == $past(instr_i[7:0])) else $error("local bad");
   chk_ptr_step: assert property (
      take |=> instruction_pointer_o ==
      $past(instruction_pointer_o) + 12'h001)
      else $error("pointer step wrong");
   chk_ind_fetch: assert property (
      take && instr_i[8] |-> ##2 mem_req_o.rd &&
      mem_req_o.addr == $past(dea, 2))
      else $error("pointer fetch wrong");
   chk_direct_quiet: assert property (
      take && !instr_i[8] |=> !(mem_req_o.rd || mem_req_o.wr) [*2])
      else $error("direct access touched memory");
   chk_intr_save: assert property (
      !busy_o && intr_i |=> mem_req_o.wr && mem_req_o.addr == INT_SAVE_A
      && mem_req_o.wdata == $past(instruction_pointer_o))
      else $error("save bad");
   chk_field_sel: assert property (
      mem_req_o.rd |-> mem_req_o.field == $past(data_field_i))
      else $error("field wrong");
   chk_bad_opcode: assert property (
      !busy_o && instr_valid_i && instr_i[11:9] > 3'h5 && !intr_i && !load_pc_i
      && !advance_i |=> !busy_o && $stable(instruction_pointer_o))
      else $error("opcode not refused");
endmodule
bind pea_unit pea_unit_sva u_sva (.*);

//--- tb/pea_core_mem.sv
// core memory model: read data follows a read strobe by one clock
`timescale 1ns/100ps
module pea_core_mem
   import pea_pkg::*;
(
   input  wire logic         clk_sys_i,
   input  wire pea_mem_req_t req_i,
   output logic [11:0]       rdata_o,
   output logic [2:0]        field_o
);
   logic [11:0] m [0:4095];
   // contents differ from the address so a wrong fetch shows up
   initial begin
      for (int i = 0; i < 4096; i++) m[i] = ~12'(i);
   end
   always @(posedge clk_sys_i) begin
      if (req_i.rd) begin
         rdata_o <= m[req_i.addr];
         field_o <= req_i.field;
      end
      if (req_i.wr) m[req_i.addr] <= req_i.wdata;
   end
endmodule

//--- tb/pea_unit_tb.sv
// self-checking bench of the paged effective address unit
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
   mismatches++; $display("BAD %0t %h %h", $time, a, b); end end
module pea_unit_tb
   import pea_pkg::*;
;
   logic         clk_sys_i, rst_n_i, instr_valid_i, advance_i, skip_i;
   logic         load_pc_i, intr_i, busy_o;
   logic [11:0]  instr_i, load_pc_val_i, mem_rdata_i, got, e;
   logic [11:0]  instruction_pointer_o;
   logic [2:0]   data_field_i, fld;
   logic [7:0]   local_addr_o;
   pea_mem_req_t mem_req_o;
   pea_result_t  result_o;
   int           mismatches, samples_checked;
   // short memory cycle keeps the run brief
   pea_unit #(.CYC_CLKS(2)) dut (.*);
   pea_core_mem u_mem (.clk_sys_i(clk_sys_i), .req_i(mem_req_o),
      .rdata_o(mem_rdata_i), .field_o(fld));
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic settle();
      got = 12'hXXX;
      for (int n = 0; n < 200; n++) begin
         #1;
         if (result_o.valid) got = result_o.ea;
         if (!busy_o) return;
         @(posedge clk_sys_i);
      end
      mismatches++;
      complete_run();
   endtask
   // k = {interrupt, instruction, load, advance, skip}
   task automatic drive(input logic [4:0] k, input logic [11:0] v);
      @(posedge clk_sys_i);
      {intr_i, instr_valid_i, load_pc_i, advance_i, skip_i} <= k;
      instr_i <= v;
      load_pc_val_i <= v;
      @(posedge clk_sys_i);
      {intr_i, instr_valid_i, load_pc_i, advance_i, skip_i} <= 5'h00;
      settle();
   endtask
   task automatic t_page();
      drive(5'h04, 12'h17F);
      drive(5'h08, 12'h285);
      `CHK(got, 12'h105)
      `CHK(local_addr_o, 8'h85)
      `CHK(instruction_pointer_o, 12'h180)
      drive(5'h02, 12'h000);
      drive(5'h03, 12'h000);
      `CHK(instruction_pointer_o, 12'h183)
   endtask
   task automatic t_ops();
      for (int op = 0; op < 6; op++) begin
         drive(5'h08, {3'(op), 9'h00A});
         `CHK(got, 12'h00A)
         `CHK(result_o.opcode, 3'(op))
         `CHK(result_o.ind, 1'b0)
      end
      `CHK(u_mem.m[12'h00A], ~12'h00A)
      e = instruction_pointer_o;
      drive(5'h08, 12'hC0A);
      `CHK(instruction_pointer_o, e)
   endtask
   task automatic t_ind();
      @(posedge clk_sys_i);
      data_field_i <= 3'h5;
      drive(5'h04, 12'h200);
      drive(5'h08, 12'h7B3);
      `CHK(got, 12'hDCC)
      `CHK(result_o.ind, 1'b1)
      `CHK(fld, 3'h5)
      // pointer word at the very top of the field, page 37 offset 177
      drive(5'h04, 12'hFC0);
      drive(5'h08, 12'h1FF);
      `CHK(got, ~12'hFFF)
   endtask
   task automatic t_auto();
      for (int a = 7; a < 17; a++) begin
         u_mem.m[a] = (a == 15) ? 12'hFFF : 12'(a << 4);
         e = u_mem.m[a] + ((a > 7 && a < 16) ? 12'h001 : 12'h000);
         drive(5'h08, 12'h100 | 12'(a));
         `CHK(got, e)
         `CHK(u_mem.m[a], e)
      end
   endtask
   task automatic t_intr();
      drive(5'h04, 12'h345);
      drive(5'h10, 12'h000);
      `CHK(u_mem.m[INT_SAVE_A], 12'h345)
      `CHK(instruction_pointer_o, INT_VEC_A)
   endtask
   initial begin
      {rst_n_i, intr_i, instr_valid_i, load_pc_i, advance_i, skip_i} = 6'h00;
      instr_i = 12'h000;
      load_pc_val_i = 12'h000;
      data_field_i = 3'h2;
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      #1;
      `CHK({busy_o, instruction_pointer_o, result_o}, 30'h0)
      t_page();
      t_ops();
      t_ind();
      t_auto();
      t_intr();
      complete_run();
   end
endmodule
